// ---- dv/ssd_datapath_tb.sv ----
// Self-checking bench of the serial data path: AXI4-Lite master tasks
// and a remote slave on the wires. Assumes pull-ups on all link wires.
`timescale 1ns/1ps
`default_nettype none
`include "ssd_params.svh"
module ssd_datapath_tb import ssd_pkg::*;;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, rem_tx = 8'h00, d;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0, msb = 1'h0;
  logic [31:0] wdata = 32'h0000_0000, rdata, got;
  logic awready, wready, bvalid, arready, rvalid, miso;
  logic [1:0] bresp, rresp, resp;
  logic [7:0] rem_rx;
  ssd_pin_t sclk_d, cs_d, do_d, di_d;
  int failures = 0;
  int check_count = 0;
  // Wired-and with pull-ups, so open drain resolves as on the board
  wire sclk_w = sclk_d.oe_n | sclk_d.o;
  wire cs_w = cs_d.oe_n | cs_d.o;
  wire mosi_w = do_d.oe_n | do_d.o;
  wire miso_w = (di_d.oe_n | di_d.o) & miso;

  always #25 aclk = ~aclk;

  ssd_datapath i_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .serial_clock_pin_i(sclk_w), .chip_select_pin_n_i(cs_w),
    .data_out_pin_i(mosi_w), .data_in_pin_i(miso_w),
    .serial_clock_pin(sclk_d), .chip_select_pin_n(cs_d),
    .data_out_pin(do_d), .data_in_pin(di_d));

  ssd_remote i_rem (.sclk(sclk_w), .cs_n(cs_w), .mosi(mosi_w), .miso(miso),
    .msb(msb), .tx_byte(rem_tx), .rx_byte(rem_rx));

  // Compare one value and count it
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e)
    begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Both write channels offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int t;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    t = 0;
    do
    begin
      @(posedge aclk);
      if (awready === 1'h1) awvalid <= 1'h0;
      if (wready === 1'h1) wvalid <= 1'h0;
      t++;
    end
    while (bvalid !== 1'h1 && t < 200);
    chk({31'h0, bvalid}, 32'h0000_0001);
    bready <= 1'h0;
  endtask

  // Read one word; data and response land in got and resp
  task automatic rd(input logic [7:0] a);
    int t;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    t = 0;
    do
    begin
      @(posedge aclk);
      if (arready === 1'h1) arvalid <= 1'h0;
      t++;
    end
    while (rvalid !== 1'h1 && t < 200);
    chk({31'h0, rvalid}, 32'h0000_0001);
    got = rdata;
    resp = rresp;
    rready <= 1'h0;
  endtask

  task automatic end_sim();
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Main sequence: map corners, then master frames in both bit orders
  initial
  begin
    void'($urandom(32'hfe8a));
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    rd(`SSD_CR2_OFS);
    chk(got, 32'h0000_0000);
    rd(8'h2C);
    chk({30'h0, resp}, {30'h0, `SSD_RESP_SLVERR});
    wr(`SSD_CR2_OFS, 32'h0000_00FF);
    rd(`SSD_CR2_OFS);
    chk(got, 32'h0000_00FC);
    wr(`SSD_RX0_OFS, 32'h0000_0055);
    rd(`SSD_RX0_OFS);
    chk(got, 32'h0000_0000);
    $display("register test done");
    for (int i = 0; i < 4; i++)
    begin
      msb <= i[0];
      rem_tx <= 8'($urandom);
      d = 8'($urandom);
      // Rate code 2: a half period must cover the pad synchroniser delay
      wr(`SSD_CTRL_OFS, 32'h0000_021A | {26'h0, i[0], 5'h00});
      wr(`SSD_TX0_OFS, {24'h0, d});
      got = 32'h0000_0000;
      // Wait for received data and the lag to finish before moving on
      for (int k = 0; k < 100 && {got[3], got[1]} !== 2'h1; k++)
        rd(`SSD_STAT_OFS);
      chk({28'h0, got[3:0]}, 32'h0000_0007);
      chk({24'h0, rem_rx}, {24'h0, d});
      rd(`SSD_RX0_OFS);
      chk(got, {24'h0, rem_tx});
      $display("frame test %0d done", i);
    end
    end_sim();
  end

  // Watchdog, far beyond the few hundred cycles the tests need
  initial
  begin
    #2_000_000;
    failures++;
    end_sim();
  end
endmodule
`default_nettype wire

// ---- dv/ssd_remote.sv ----
// Remote four-wire slave: shifts out one byte, captures the master byte.
// Assumes pull-ups on every wire, idle-high clock and phase 0 timing.
`timescale 1ns/1ps
`default_nettype none
module ssd_remote
(
  // Link wires
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  // Test side
  input wire logic msb,
  input wire logic [7:0] tx_byte,
  output logic [7:0] rx_byte
);
  logic [7:0] sh = 8'h00;
  int n = 0;
  // Load the reply and restart the bit count as select falls
  always @(negedge cs_n)
  begin
    sh = tx_byte;
    n = 0;
  end
  // Leading edge presents the next bit; the first is already out
  always @(negedge sclk)
    if (!cs_n && n != 0)
      sh = msb ? {sh[6:0], 1'h0} : {1'h0, sh[7:1]};
  // Trailing edge latches the master bit, first bit lands per bit order
  always @(posedge sclk)
    if (!cs_n)
    begin
      rx_byte = msb ? {rx_byte[6:0], mosi} : {mosi, rx_byte[7:1]};
      n++;
    end
  // Unselected, the line is left to its pull-up
  assign miso = cs_n ? 1'h1 : (msb ? sh[7] : sh[0]);
endmodule
`default_nettype wire

// ---- hw/ssd_datapath.sv ----
// ssd_datapath.sv: data registers, shift engine and pin control of a
// synchronous serial unit, with an AXI4-Lite register slave.
// Assumes one 20 MHz clock; pin inputs are asynchronous and the pads
// resolve each wire from o and oe_n.
//
// Overview of operation
// - Bits 7,6,5 pick open-drain for data, clock and select outputs.
// - Bit 4: done flag during last bit, or after it, master four-wire.
// - Bit 3: select lead and lag of half or one and a half clocks.
// - Bit 2: master data output driven only while select is low.
// - Bits 1 and 0 read zero; software writes zero.
// - Four transmit bytes; frame length picks valid ones; code 3 none.
// - Four receive bytes, valid by frame length like transmit bytes.
// - Empty shifter loads pending data; pending data follows back to back.
// - Finished frame copied to receive bytes, freeing the shifter.
// - Receive bytes ignore writes; read after full flag is set.
// - Load puts bit 0 or the frame top bit (7, 15 or 31) first; output always from shift bit 0.
// - Received bits enter at the frame top bit (7, 15 or 31); shifter not software visible.
// - Bit order select: 0 least first, 1 most first.
// - Master drives clock at one of seven rates; slave takes clock in.
// - Four-wire honours phase and polarity; synchronous mode only polarity.
// - Four-wire master sends on data-out; slave sends on data-in.
// - Bidirectional mode uses data-out only, one direction at a time.
// - Synchronous mode sends data-out, receives data-in, clock by master.
// - Pins switch input, output or unused by mode and enables.
// - Length code 0,1,2 give 8,16,32 bits; 3 prohibited.
// - Transfer mode 0 is four-wire, 1 is clock-synchronous.
// - Master select 1 makes the device master, 0 slave.
`timescale 1ns/1ps
`default_nettype none
`include "ssd_params.svh"
module ssd_datapath
  import ssd_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write channels
  input wire logic [`SSD_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [`SSD_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pin levels seen at the pads
  input wire logic serial_clock_pin_i,
  input wire logic chip_select_pin_n_i,
  input wire logic data_out_pin_i,
  input wire logic data_in_pin_i,
  // Pin drives
  output ssd_pin_t serial_clock_pin,
  output ssd_pin_t chip_select_pin_n,
  output ssd_pin_t data_out_pin,
  output ssd_pin_t data_in_pin
);
  ssd_ctrl_t ctrl_reg;
  ssd_cr2_t cr2_reg;
  ssd_state_t state_reg;
  logic [31:0] tx_data_reg, rx_data_reg, sr_reg, sr_shift, rdata_next;
  logic [3:0] sync1_reg, sync2_reg, sync3_reg;
  logic [7:0] div_reg, half_m1, waddr_reg;
  logic [15:0] wdata_reg;
  logic [1:0] wstrb_reg, len, maxidx, hcnt_reg, lead_n, lag_n, rresp_next;
  logic [6:0] edge_reg, n_edges;
  logic [2:0] rate_eff;
  logic tx_empty_reg, rx_full_reg, tx_done_reg, sck_act_reg, cs_act_reg;
  logic rx_bit_reg, dout_bit_reg, mw;
  logic four_wire, is_master, bidi, eff_phase, tx_on, rx_on, len_ok;
  logic tick, slave_edge, edge_ev, last_edge, more, start, load_ev;
  logic cs_sel, rx_pin, samp_bit, td_set, drive, tx_on_din;
  logic wr_go, ar_fire, w_map, commit, rd_rx;

  // Reorder a frame word for the bit order; shared by load and copy
  function automatic logic [31:0] ssd_order(input logic [31:0] w,
                                            input logic [1:0] l,
                                            input logic msb);
    logic [31:0] r;
    r = w;
    if (msb)
    begin
      for (int i = 0; i < 32; i++)
        r[i] = w[31 - i];
      if (l == `SSD_LEN_8)
        r = r >> 24;
      else if (l == `SSD_LEN_16)
        r = r >> 16;
    end
    return r;
  endfunction

  // Right shift, new bit enters at the frame top; lands at bit 0 last
  function automatic logic [31:0] ssd_shift(input logic [31:0] s,
                                            input logic b,
                                            input logic [1:0] l);
    logic [31:0] r;
    r = s >> 1;
    if (l == `SSD_LEN_8)
      r[7] = b;
    else if (l == `SSD_LEN_16)
      r[15] = b;
    else
      r[31] = b;
    return r;
  endfunction

  // Two flops before use; the third stage only feeds the edge detect
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync1_reg <= 4'hf;
      sync2_reg <= 4'hf;
      sync3_reg <= 4'hf;
    end
    else
    begin
      sync1_reg <= {serial_clock_pin_i, chip_select_pin_n_i, data_out_pin_i, data_in_pin_i};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // Mode decode
  assign len = ctrl_reg.frame_length_select;
  assign four_wire = ~ctrl_reg.transfer_mode_select;
  assign is_master = ctrl_reg.master_select;
  assign bidi = ctrl_reg.bidirectional_select & four_wire;
  // High: data changes on the first edge, latched on the second
  assign eff_phase = ~(four_wire & ctrl_reg.clock_phase_select);
  assign tx_on = ctrl_reg.tx_enable;
  assign rx_on = ctrl_reg.rx_enable & ~(bidi & tx_on);
  assign len_ok = len != `SSD_LEN_RSVD;
  assign maxidx = (len == `SSD_LEN_8) ? 2'd0 : (len == `SSD_LEN_16) ? 2'd1 : 2'd3;
  assign n_edges = (len == `SSD_LEN_8) ? `SSD_EDGES_8 :
                   (len == `SSD_LEN_16) ? `SSD_EDGES_16 : `SSD_EDGES_32;
  assign lead_n = cr2_reg.chip_select_lead_select ? `SSD_HALF_LONG : `SSD_HALF_SHORT;
  assign lag_n = lead_n;
  // Reserved rate code runs at the fastest rate rather than stalling
  assign rate_eff = (ctrl_reg.clock_rate_select < `SSD_RATE_MIN) ? `SSD_RATE_MIN
                                                                : ctrl_reg.clock_rate_select;
  assign half_m1 = (8'd1 << rate_eff) - 8'd1;

  // Data source pin by role and mode
  assign tx_on_din = four_wire & ~bidi & ~is_master;
  assign rx_pin = ((four_wire & ~bidi & is_master) | ~four_wire) ? sync2_reg[0]
                                                                   : sync2_reg[1];
  assign cs_sel = ~four_wire | ~sync2_reg[2];

  // Transfer events
  assign tick = (state_reg != st_idle) & (div_reg == half_m1);
  assign slave_edge = sync2_reg[3] ^ sync3_reg[3];
  assign edge_ev = (state_reg == st_shift) & (is_master ? tick : slave_edge);
  assign last_edge = edge_ev & ((edge_reg + 7'd1) == n_edges);
  assign more = tx_on & ~tx_empty_reg;
  assign start = (state_reg == st_idle) & len_ok & (is_master ?
                 (tx_on ? ~tx_empty_reg : rx_on & ~rx_full_reg) :
                 ((tx_on | rx_on) & cs_sel));
  assign load_ev = (start & more) | (last_edge & more);
  assign samp_bit = eff_phase ? rx_pin : rx_bit_reg;
  assign sr_shift = ssd_shift(sr_reg, samp_bit, len);

  // Sequencer, transfer clock divider and select timing
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg <= st_idle;
      div_reg <= 8'h00;
      hcnt_reg <= 2'h0;
      edge_reg <= 7'h00;
      sck_act_reg <= 1'b0;
      cs_act_reg <= 1'b0;
    end
    else
    begin
      div_reg <= (state_reg == st_idle || tick) ? 8'h00 : div_reg + 8'h01;
      if (edge_ev)
      begin
        edge_reg <= last_edge ? 7'h00 : edge_reg + 7'h01;
        sck_act_reg <= ~sck_act_reg;
      end
      case (state_reg)
        st_idle:
        begin
          hcnt_reg <= 2'h0;
          sck_act_reg <= 1'b0;
          edge_reg <= 7'h00;
          if (start)
          begin
            cs_act_reg <= four_wire & is_master;
            // Long lead holds the select two extra half periods
            if (four_wire & is_master & cr2_reg.chip_select_lead_select)
              state_reg <= st_lead;
            else
              state_reg <= st_shift;
          end
        end
        st_lead:
        begin
          if (tick)
          begin
            hcnt_reg <= hcnt_reg + 2'h1;
            if (hcnt_reg + 2'h1 == lead_n - 2'h1)
            begin
              hcnt_reg <= 2'h0;
              state_reg <= st_shift;
            end
          end
        end
        st_shift:
        begin
          if (!is_master && four_wire && sync2_reg[2])
            state_reg <= st_idle;
          else if (last_edge && !more)
            state_reg <= (is_master && four_wire) ? st_lag : st_idle;
        end
        st_lag:
        begin
          if (tick)
          begin
            hcnt_reg <= hcnt_reg + 2'h1;
            if (hcnt_reg + 2'h1 == lag_n)
            begin
              cs_act_reg <= 1'b0;
              state_reg <= st_idle;
            end
          end
        end
        default:
        begin
          state_reg <= st_idle;
          cs_act_reg <= 1'b0;
        end
      endcase
    end
  end

  // Shift register; phase decides which edge samples and which drives; shift on the second
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sr_reg <= `SSD_DATA_RST;
      rx_bit_reg <= 1'b0;
      dout_bit_reg <= 1'b0;
    end
    else if (load_ev)
    begin
      sr_reg <= ssd_order(tx_data_reg, len, ctrl_reg.bit_order_select);
      dout_bit_reg <= tx_data_reg[ctrl_reg.bit_order_select ? {maxidx, 3'h7} : 5'h00];
    end
    else if (edge_ev)
    begin
      if (~edge_reg[0])
      begin
        if (eff_phase)
          dout_bit_reg <= sr_reg[0];
        else
          rx_bit_reg <= rx_pin;
      end
      else
      begin
        sr_reg <= sr_shift;
        if (!eff_phase)
          dout_bit_reg <= sr_shift[0];
      end
    end
  end

  // Done flag timing
  always_comb
  begin
    if (four_wire && is_master && cr2_reg.tx_done_timing_select)
      td_set = (state_reg == st_lag) & tick & (hcnt_reg + 2'h1 == lag_n);
    else if (four_wire && is_master)
      td_set = edge_ev & ((edge_reg + 7'd2) == n_edges) & ~more;
    else
      td_set = last_edge & ~more;
    td_set = td_set & tx_on & tx_empty_reg;
  end

  // AXI4-Lite handshakes; one write and one read outstanding
  assign wr_go = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  assign ar_fire = s_axi_arvalid & s_axi_arready;
  assign mw = waddr_reg[1:0] == 2'h0;
  assign w_map = mw & (waddr_reg <= `SSD_STAT_OFS);
  assign commit = wr_go & wstrb_reg[0] & len_ok & (waddr_reg[7:2] - 6'h02 == {4'h0, maxidx})
                  & (waddr_reg >= `SSD_TX0_OFS) & mw;
  assign rd_rx = ar_fire & len_ok & (s_axi_araddr[1:0] == 2'h0) &
                 (s_axi_araddr >= `SSD_RX0_OFS) &
                 (s_axi_araddr < `SSD_RX0_OFS + `SSD_DATA_SPAN) &
                 (s_axi_araddr[3:2] - 2'h2 <= maxidx);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SSD_RESP_OKAY;
      waddr_reg <= 8'h00;
      wdata_reg <= 16'h0000;
      wstrb_reg <= 2'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        s_axi_awready <= 1'b0;
        waddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        s_axi_wready <= 1'b0;
        wdata_reg <= s_axi_wdata[15:0];
        wstrb_reg <= s_axi_wstrb[1:0];
      end
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= w_map ? `SSD_RESP_OKAY : `SSD_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Software-written configuration and transmit bytes
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_reg <= `SSD_CTRL_RST;
      cr2_reg <= `SSD_CR2_RST;
      tx_data_reg <= `SSD_DATA_RST;
    end
    else if (wr_go && mw)
    begin
      if (waddr_reg == `SSD_CTRL_OFS)
      begin
        if (wstrb_reg[0])
          ctrl_reg[7:0] <= wdata_reg[7:0];
        if (wstrb_reg[1])
          ctrl_reg[12:8] <= wdata_reg[12:8];
      end
      if (waddr_reg == `SSD_CR2_OFS && wstrb_reg[0])
        cr2_reg <= wdata_reg[7:2];
      // Bytes beyond the frame length are not stored
      if (waddr_reg >= `SSD_TX0_OFS && waddr_reg < `SSD_RX0_OFS && wstrb_reg[0] &&
          len_ok && (waddr_reg[3:2] - 2'h2 <= maxidx))
        tx_data_reg[{waddr_reg[3:2] - 2'h2, 3'h0} +: 8] <= wdata_reg[7:0];
    end
  end

  // Flags and receive bytes; hardware set of done and full wins over a same-cycle clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_empty_reg <= 1'b1;
      tx_done_reg <= 1'b0;
      rx_full_reg <= 1'b0;
      rx_data_reg <= `SSD_DATA_RST;
    end
    else
    begin
      // New data written during a load stays pending
      if (!tx_on)
        tx_empty_reg <= 1'b1;
      else if (commit)
        tx_empty_reg <= 1'b0;
      else if (load_ev)
        tx_empty_reg <= 1'b1;
      if (td_set)
        tx_done_reg <= 1'b1;
      else if (commit)
        tx_done_reg <= 1'b0;
      // A frame finishing while full is dropped, old bytes kept
      if (last_edge && rx_on && !rx_full_reg && len_ok)
      begin
        rx_data_reg <= ssd_order(sr_shift, len, ctrl_reg.bit_order_select);
        rx_full_reg <= 1'b1;
      end
      else if (rd_rx)
        rx_full_reg <= 1'b0;
    end
  end

  // Read data mux; invalid data bytes read zero
  always_comb
  begin
    rdata_next = 32'h0000_0000;
    rresp_next = `SSD_RESP_OKAY;
    if (s_axi_araddr[1:0] != 2'h0 || s_axi_araddr > `SSD_STAT_OFS)
      rresp_next = `SSD_RESP_SLVERR;
    else if (s_axi_araddr == `SSD_CTRL_OFS)
      rdata_next = {19'h0_0000, ctrl_reg};
    else if (s_axi_araddr == `SSD_CR2_OFS)
      rdata_next = {24'h00_0000, cr2_reg, 2'b00};
    else if (s_axi_araddr == `SSD_STAT_OFS)
      rdata_next = {28'h000_0000, state_reg != st_idle, tx_done_reg, rx_full_reg,
                    tx_empty_reg};
    else if (len_ok && (s_axi_araddr[3:2] - 2'h2 <= maxidx))
      rdata_next = {24'h00_0000, (s_axi_araddr < `SSD_RX0_OFS) ?
                    tx_data_reg[{s_axi_araddr[3:2] - 2'h2, 3'h0} +: 8] :
                    rx_data_reg[{s_axi_araddr[3:2] - 2'h2, 3'h0} +: 8]};
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `SSD_RESP_OKAY;
    end
    else if (ar_fire)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdata_next;
      s_axi_rresp <= rresp_next;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Pin drives; open drain only ever pulls low
  assign drive = tx_on & len_ok & (~four_wire | (is_master ?
                 (~cr2_reg.data_out_gating_select | cs_act_reg) : ~sync2_reg[2]));
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      serial_clock_pin <= 2'b01;
      chip_select_pin_n <= 2'b01;
      data_out_pin <= 2'b01;
      data_in_pin <= 2'b01;
    end
    else
    begin
      serial_clock_pin.o <= ~cr2_reg.clock_out_drain_select &
                            (~ctrl_reg.clock_idle_polarity ^ sck_act_reg);
      serial_clock_pin.oe_n <= ~(is_master & (~cr2_reg.clock_out_drain_select |
                               ~(~ctrl_reg.clock_idle_polarity ^ sck_act_reg)));
      chip_select_pin_n.o <= ~cr2_reg.cs_drain_select & ~cs_act_reg;
      chip_select_pin_n.oe_n <= ~(is_master & four_wire &
                                  (~cr2_reg.cs_drain_select | cs_act_reg));
      data_out_pin.o <= ~cr2_reg.data_out_drain_select & dout_bit_reg;
      data_out_pin.oe_n <= ~(drive & ~tx_on_din &
                             (~cr2_reg.data_out_drain_select | ~dout_bit_reg));
      data_in_pin.o <= ~cr2_reg.data_out_drain_select & dout_bit_reg;
      data_in_pin.oe_n <= ~(drive & tx_on_din &
                            (~cr2_reg.data_out_drain_select | ~dout_bit_reg));
    end
  end

  default clocking chk_cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_reserved_zero: assert property (
    (ar_fire && s_axi_araddr == `SSD_CR2_OFS) |=> s_axi_rdata[1:0] == 2'b00)
    else $error("reserved control bits read nonzero");
  chk_rx_readonly: assert property (
    (wr_go && waddr_reg >= `SSD_RX0_OFS && !last_edge) |=> $stable(rx_data_reg))
    else $error("receive bytes changed by a write");
  chk_od_data: assert property (
    (!data_out_pin.oe_n && $past(cr2_reg.data_out_drain_select)) |-> !data_out_pin.o)
    else $error("open-drain data pin driven high");
  chk_gate_select: assert property (
    (!data_out_pin.oe_n && $past(is_master && four_wire && cr2_reg.data_out_gating_select))
    |-> $past(cs_act_reg))
    else $error("gated data driven with select high");
  chk_din_unused: assert property (
    $past(bidi) |-> data_in_pin.oe_n)
    else $error("data-in pin driven in bidirectional mode");
  chk_slave_clock: assert property (
    $past(!is_master) |-> serial_clock_pin.oe_n)
    else $error("slave drove the clock pin");
  chk_rx_copy: assert property (
    (last_edge && rx_on && !rx_full_reg && len_ok) |=>
    rx_full_reg ##1 (rx_full_reg || $past(rd_rx)))
    else $error("finished frame not copied");
  chk_back_to_back: assert property (
    (last_edge && is_master && more) |=> state_reg == st_shift)
    else $error("gap between back to back frames");
  chk_len_rsvd: assert property (
    (state_reg == st_idle && !len_ok) |=> state_reg == st_idle)
    else $error("frame started with reserved length");
  chk_long_lead: assert property (
    (state_reg == st_idle && start && is_master && four_wire &&
     cr2_reg.chip_select_lead_select) |=> state_reg == st_lead [*2])
    else $error("long lead skipped");
  cov_b2b: cover property (last_edge && more);
  cov_slave_frame: cover property (last_edge && !is_master);
  cov_msb_rx: cover property (last_edge && ctrl_reg.bit_order_select && rx_on);
  cov_lag: cover property (state_reg == st_lag ##1 state_reg == st_idle);
endmodule
`default_nettype wire

// ---- hw/ssd_params.svh ----
// ssd_params.svh: register offsets, reset values and counts of the
// serial data path. Definitions only; included by its bare name.
`ifndef SSD_PARAMS_SVH
`define SSD_PARAMS_SVH
`define SSD_AW 8
`define SSD_CTRL_OFS 8'h00
`define SSD_CR2_OFS 8'h04
`define SSD_TX0_OFS 8'h08
`define SSD_RX0_OFS 8'h18
`define SSD_STAT_OFS 8'h28
`define SSD_DATA_SPAN 8'h10
`define SSD_CTRL_RST 13'h0000
`define SSD_CR2_RST 6'h00
`define SSD_DATA_RST 32'h0000_0000
`define SSD_LEN_8 2'h0
`define SSD_LEN_16 2'h1
`define SSD_LEN_RSVD 2'h3
`define SSD_EDGES_8 7'h10
`define SSD_EDGES_16 7'h20
`define SSD_EDGES_32 7'h40
`define SSD_HALF_SHORT 2'h1
`define SSD_HALF_LONG 2'h3
`define SSD_RATE_MIN 3'h1
`define SSD_RESP_OKAY 2'h0
`define SSD_RESP_SLVERR 2'h2
`endif

// ---- hw/ssd_pkg.sv ----
// ssd_pkg.sv: types of the serial data path.
// Offsets and counts live in ssd_params.svh.
package ssd_pkg;
  typedef enum logic [3:0]
  {
    st_idle = 4'h1,
    st_lead = 4'h2,
    st_shift = 4'h4,
    st_lag = 4'h8
  } ssd_state_t;
  // Own configuration word, bit 0 is transfer_mode_select
  typedef struct packed {
    logic [1:0] frame_length_select;
    logic [2:0] clock_rate_select;
    logic clock_phase_select;
    logic clock_idle_polarity;
    logic bit_order_select;
    logic rx_enable;
    logic tx_enable;
    logic bidirectional_select;
    logic master_select;
    logic transfer_mode_select;
  } ssd_ctrl_t;
  // Bits 7..2 of serial_control_two
  typedef struct packed {
    logic data_out_drain_select;
    logic clock_out_drain_select;
    logic cs_drain_select;
    logic tx_done_timing_select;
    logic chip_select_lead_select;
    logic data_out_gating_select;
  } ssd_cr2_t;
  // Pad drive: value and active-low enable
  typedef struct packed {
    logic o;
    logic oe_n;
  } ssd_pin_t;
endpackage
